//--- rtl/cwdp_ext_gate.sv
// Purpose: decide what an external programmer access may do.
// Assumes: request fields stable while valid.
// Notes: configuration-space reads are served locally and never gated.
module cwdp_ext_gate (
    input cwdp_pkg::cwdp_req_s req,
    input wire logic [13:0] prot_word,
    input wire logic [13:0] mem_word,
    input wire logic lv_prog_active,
    output logic mem_go,
    output logic rd_zero,
    output logic wr_block,
    output logic uid_wr
);
    // protection decision per address space
    always_comb begin
        logic guarded;
        logic uid_hit;
        logic cfg_hit;
        guarded = 1'b0;
        uid_hit = req.addr >= cwdp_pkg::UID_BASE && req.addr <= cwdp_pkg::UID_LAST;
        cfg_hit = req.addr == cwdp_pkg::WDT_ADDR || req.addr == cwdp_pkg::MEM_ADDR
            || req.addr == cwdp_pkg::PROT_ADDR;
        mem_go = 1'b0;
        rd_zero = 1'b0;
        wr_block = 1'b0;
        uid_wr = 1'b0;
        if (req.space == cwdp_pkg::SP_PROG || req.space == cwdp_pkg::SP_EE) begin
            if (req.space == cwdp_pkg::SP_PROG) begin
                guarded = !prot_word[cwdp_pkg::CP_BIT];
            end else begin
                guarded = !prot_word[cwdp_pkg::CPD_BIT];
            end
            mem_go = !guarded;
            rd_zero = guarded && !req.write;
            wr_block = guarded && req.write;
        end else if (req.space == cwdp_pkg::SP_CFG) begin
            if (req.write) begin
                if (uid_hit) begin
                    uid_wr = 1'b1;
                end else if (req.addr == cwdp_pkg::MEM_ADDR && lv_prog_active
                        && mem_word[cwdp_pkg::LVP_BIT] && !req.wdata[cwdp_pkg::LVP_BIT]) begin
                    wr_block = 1'b1; // no self-lockout over the low-voltage port
                end else if (cfg_hit) begin
                    mem_go = 1'b1;
                end else begin
                    wr_block = 1'b1; // ids and holes are read-only
                end
            end
        end else begin
            wr_block = req.write;
        end
    end
endmodule

//--- rtl/cwdp_pkg.sv
// Purpose: shared constants and carriers for the configuration word decoder.
// Assumes: 14-bit configuration words, 16-bit configuration-space addresses.
// Notes: erased nonvolatile cells read as all ones.
package cwdp_pkg;
    // word layout
    localparam logic [13:0] ERASED = 14'h3FFF;
    localparam logic [13:0] WDT_IMPL = 14'h3F7F;
    localparam logic [13:0] MEM_IMPL = 14'h3003;
    localparam logic [13:0] PROT_IMPL = 14'h0003;
    localparam int WIN_LSB = 8;
    localparam int CLK_LSB = 11;
    localparam int MODE_LSB = 5;
    localparam int PER_LSB = 0;
    localparam int LVP_BIT = 13;
    localparam int SCAN_BIT = 12;
    localparam int WRT_LSB = 0;
    localparam int CP_BIT = 0;
    localparam int CPD_BIT = 1;

    // watchdog field codes
    localparam logic [2:0] WIN_OPEN_MIN = 3'h6;
    localparam logic [2:0] WIN_FULL = 3'h7;
    localparam logic [2:0] WIN_NONE = 3'h0;
    localparam logic [1:0] MODE_ALWAYS = 2'h3;
    localparam logic [1:0] MODE_AWAKE = 2'h2;
    localparam logic [1:0] MODE_SOFT = 2'h1;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [4:0] PER_MAX = 5'h12;
    localparam logic [4:0] PER_ERASED = 5'h1F;
    localparam logic [4:0] PER_EXP_MIN = 5'h05;
    localparam logic [2:0] CSEL_LF = 3'h0;
    localparam logic [2:0] CSEL_MF = 3'h1;
    localparam logic [2:0] CSEL_SW = 3'h7;

    // self-write guard codes and protected upper limits
    localparam logic [1:0] WRT_OFF = 2'h3;
    localparam logic [1:0] WRT_BOOT = 2'h2;
    localparam logic [1:0] WRT_HALF = 2'h1;
    localparam logic [13:0] LIM_BOOT = 14'h01FF;
    localparam logic [13:0] LIM_HALF = 14'h1FFF;
    localparam logic [13:0] LIM_ALL = 14'h3FFF;

    // configuration space map
    localparam logic [15:0] UID_BASE = 16'h8000;
    localparam logic [15:0] UID_LAST = 16'h8003;
    localparam logic [15:0] REV_ADDR = 16'h8005;
    localparam logic [15:0] DEV_ADDR = 16'h8006;
    localparam logic [15:0] WDT_ADDR = 16'h8009;
    localparam logic [15:0] MEM_ADDR = 16'h800A;
    localparam logic [15:0] PROT_ADDR = 16'h800B;
    localparam int UID_NUM = 4;
    localparam logic [1:0] REV_FIXED = 2'h2;
    localparam logic [13:0] ZERO_WORD = 14'h0000;

    typedef enum logic [1:0] {WCLK_LF, WCLK_MF, WCLK_SW, WCLK_RSVD} cwdp_wclk_e;
    typedef enum logic [1:0] {SP_PROG, SP_EE, SP_CFG} cwdp_space_e;

    typedef struct packed {
        logic [13:0] wdt;
        logic [13:0] mem;
        logic [13:0] prot;
    } cwdp_cfg_s;

    typedef struct packed {
        logic valid;
        logic write;
        cwdp_space_e space;
        logic [15:0] addr;
        logic [13:0] wdata;
    } cwdp_req_s;

    typedef struct packed {
        logic valid;
        logic denied;
        logic [13:0] rdata;
    } cwdp_rsp_s;

    typedef struct packed {
        logic run;
        logic [2:0] window_live;
        logic [2:0] window_closed;
        logic window_sw;
        logic window_key;
        logic [4:0] period_live;
        logic [4:0] period_exp;
        logic period_sw;
        cwdp_wclk_e clk_sel;
        logic clk_sw;
    } cwdp_wdt_s;
endpackage

//--- rtl/cwdp_top.sv
// Purpose: latch configuration words at reset and drive watchdog, pin,
//          scanner, self-write and code-protection decisions from them.
// Assumes: nvm_cfg is stable from reset until the first edge after release.
// Notes: external requests answer two edges later; cpu config requests one edge later.

module cwdp_top #(
    parameter logic [13:0] DEVICE_ID = 14'h1234, // arbitrary value
    parameter logic [5:0] REV_MAJOR = 6'h01, // arbitrary value
    parameter logic [5:0] REV_MINOR = 6'h02 // arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input cwdp_pkg::cwdp_cfg_s nvm_cfg,
    input wire logic sleep,
    input wire logic watchdog_soft_on,
    input wire logic ext_reset_pin_enable,
    input wire logic ext_reset_pin_n,
    input wire logic hv_detect,
    input wire logic lv_key_ok,
    input wire logic lv_prog_active,
    input wire logic scanner_module_off,
    input wire logic sw_req,
    input wire logic [13:0] sw_addr,
    input cwdp_pkg::cwdp_req_s ext_req,
    input wire logic [13:0] mem_rdata,
    input cwdp_pkg::cwdp_req_s cpu_req,
    output logic cfg_loaded,
    output cwdp_pkg::cwdp_wdt_s wdt,
    output logic reset_pin_is_reset,
    output logic ext_reset_hold,
    output logic prog_entry,
    output logic scanner_avail,
    output logic scanner_on,
    output logic sw_ack,
    output logic sw_blocked,
    output cwdp_pkg::cwdp_req_s mem_cmd,
    output cwdp_pkg::cwdp_rsp_s ext_rsp,
    output cwdp_pkg::cwdp_rsp_s cpu_rsp
);
    typedef enum logic {ST_LOAD, ST_RUN} cwdp_state_e;

    cwdp_state_e state;
    cwdp_state_e next_state;
    cwdp_pkg::cwdp_cfg_s cfg;
    cwdp_pkg::cwdp_cfg_s next_cfg;
    cwdp_pkg::cwdp_wdt_s wdt_dec;
    logic [13:0] uid [cwdp_pkg::UID_NUM];
    logic g_mem_go;
    logic g_rd_zero;
    logic g_wr_block;
    logic g_uid_wr;
    logic ext_take;
    logic cpu_take;
    // first stage of the external pipeline
    cwdp_pkg::cwdp_req_s s1;
    cwdp_pkg::cwdp_req_s next_s1;
    logic s1_zero;
    logic next_s1_zero;
    logic s1_block;
    logic next_s1_block;
    logic s1_uid_wr;
    logic next_s1_uid_wr;
    logic [13:0] s1_local;
    logic [13:0] next_s1_local;

    // configuration-space read view, unimplemented bits forced high
    function automatic logic [13:0] cfg_read(input logic [15:0] addr);
        logic [13:0] v;
        v = cwdp_pkg::ZERO_WORD;
        if (addr >= cwdp_pkg::UID_BASE && addr <= cwdp_pkg::UID_LAST) begin
            v = uid[addr[1:0]];
        end else if (addr == cwdp_pkg::REV_ADDR) begin
            v = {cwdp_pkg::REV_FIXED, REV_MAJOR, REV_MINOR};
        end else if (addr == cwdp_pkg::DEV_ADDR) begin
            v = DEVICE_ID;
        end else if (addr == cwdp_pkg::WDT_ADDR) begin
            v = cfg.wdt | ~cwdp_pkg::WDT_IMPL;
        end else if (addr == cwdp_pkg::MEM_ADDR) begin
            v = cfg.mem | ~cwdp_pkg::MEM_IMPL;
        end else if (addr == cwdp_pkg::PROT_ADDR) begin
            v = cfg.prot | ~cwdp_pkg::PROT_IMPL;
        end
        return v;
    endfunction

    cwdp_wdt_decode u_wdt (
        .cfg_word(cfg.wdt),
        .sleep(sleep),
        .soft_on(watchdog_soft_on),
        .dec(wdt_dec)
    );

    cwdp_ext_gate u_gate (
        .req(ext_req),
        .prot_word(cfg.prot),
        .mem_word(cfg.mem),
        .lv_prog_active(lv_prog_active),
        .mem_go(g_mem_go),
        .rd_zero(g_rd_zero),
        .wr_block(g_wr_block),
        .uid_wr(g_uid_wr)
    );

    // requests are ignored until the words have been captured
    assign ext_take = ext_req.valid && state == ST_RUN;
    assign cpu_take = cpu_req.valid && state == ST_RUN;

    // capture once after reset release; erased image stands until then
    always_comb begin
        next_state = state;
        next_cfg = cfg;
        if (state == ST_LOAD) begin
            next_cfg = nvm_cfg;
            next_state = ST_RUN;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_LOAD;
            cfg <= '{wdt: cwdp_pkg::ERASED, mem: cwdp_pkg::ERASED, prot: cwdp_pkg::ERASED};
        end else begin
            state <= next_state;
            cfg <= next_cfg;
        end
    end

    // user id words: programmer write wins over a cpu write in the same cycle
    for (genvar i = 0; i < cwdp_pkg::UID_NUM; i++) begin : g_uid
        logic [13:0] next_uid;
        always_comb begin
            next_uid = uid[i];
            if (s1_uid_wr && s1.addr[1:0] == 2'(i)) begin
                next_uid = s1.wdata;
            end else if (cpu_take && cpu_req.write && cpu_req.addr >= cwdp_pkg::UID_BASE
                    && cpu_req.addr <= cwdp_pkg::UID_LAST && cpu_req.addr[1:0] == 2'(i)) begin
                next_uid = cpu_req.wdata;
            end
        end
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                uid[i] <= cwdp_pkg::ERASED;
            end else begin
                uid[i] <= next_uid;
            end
        end
    end

    // stage one: gate the programmer request and fetch local data
    always_comb begin
        next_s1 = ext_req;
        next_s1.valid = ext_take;
        next_s1_zero = g_rd_zero;
        next_s1_block = ext_take && g_wr_block;
        next_s1_uid_wr = ext_take && g_uid_wr;
        next_s1_local = cfg_read(ext_req.addr);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s1_zero <= 1'b0;
            s1_block <= 1'b0;
            s1_uid_wr <= 1'b0;
            s1_local <= cwdp_pkg::ZERO_WORD;
        end else begin
            s1 <= next_s1;
            s1_zero <= next_s1_zero;
            s1_block <= next_s1_block;
            s1_uid_wr <= next_s1_uid_wr;
            s1_local <= next_s1_local;
        end
    end

    // registered outputs
    cwdp_pkg::cwdp_wdt_s next_wdt;
    logic next_pin_reset;
    logic next_hold;
    logic next_prog_entry;
    logic next_scan_avail;
    logic next_scan_on;
    logic next_sw_ack;
    logic next_sw_blocked;
    cwdp_pkg::cwdp_req_s next_mem_cmd;
    cwdp_pkg::cwdp_rsp_s next_ext_rsp;
    cwdp_pkg::cwdp_rsp_s next_cpu_rsp;

    always_comb begin
        logic [13:0] lim;
        logic [1:0] guard;
        guard = cfg.mem[cwdp_pkg::WRT_LSB +: 2];
        lim = cwdp_pkg::LIM_ALL;
        next_wdt = wdt_dec;
        // low-voltage enable overrides the reset-enable bit
        next_pin_reset = cfg.mem[cwdp_pkg::LVP_BIT] || ext_reset_pin_enable;
        next_hold = next_pin_reset && !ext_reset_pin_n;
        // high voltage always enters; the key only when enabled
        next_prog_entry = hv_detect || (cfg.mem[cwdp_pkg::LVP_BIT] && lv_key_ok);
        next_scan_avail = cfg.mem[cwdp_pkg::SCAN_BIT];
        next_scan_on = cfg.mem[cwdp_pkg::SCAN_BIT] && !scanner_module_off;
        if (guard == cwdp_pkg::WRT_BOOT) begin
            lim = cwdp_pkg::LIM_BOOT;
        end else if (guard == cwdp_pkg::WRT_HALF) begin
            lim = cwdp_pkg::LIM_HALF;
        end
        next_sw_ack = sw_req && state == ST_RUN;
        next_sw_blocked = next_sw_ack && guard != cwdp_pkg::WRT_OFF && sw_addr <= lim;
        next_mem_cmd = ext_req;
        next_mem_cmd.valid = ext_take && g_mem_go;
        next_ext_rsp.valid = s1.valid;
        next_ext_rsp.denied = s1_block;
        if (s1_zero || s1.write) begin
            next_ext_rsp.rdata = cwdp_pkg::ZERO_WORD;
        end else if (s1.space == cwdp_pkg::SP_CFG) begin
            next_ext_rsp.rdata = s1_local;
        end else begin
            next_ext_rsp.rdata = mem_rdata;
        end
        // cpu program memory reads bypass this block entirely
        next_cpu_rsp.valid = cpu_take;
        next_cpu_rsp.denied = cpu_take && cpu_req.write
            && !(cpu_req.addr >= cwdp_pkg::UID_BASE && cpu_req.addr <= cwdp_pkg::UID_LAST);
        next_cpu_rsp.rdata = cpu_req.write ? cwdp_pkg::ZERO_WORD : cfg_read(cpu_req.addr);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_loaded <= 1'b0;
            wdt <= '0;
            reset_pin_is_reset <= 1'b0;
            ext_reset_hold <= 1'b0;
            prog_entry <= 1'b0;
            scanner_avail <= 1'b0;
            scanner_on <= 1'b0;
            sw_ack <= 1'b0;
            sw_blocked <= 1'b0;
            mem_cmd <= '0;
            ext_rsp <= '0;
            cpu_rsp <= '0;
        end else begin
            cfg_loaded <= state == ST_RUN;
            wdt <= next_wdt;
            reset_pin_is_reset <= next_pin_reset;
            ext_reset_hold <= next_hold;
            prog_entry <= next_prog_entry;
            scanner_avail <= next_scan_avail;
            scanner_on <= next_scan_on;
            sw_ack <= next_sw_ack;
            sw_blocked <= next_sw_blocked;
            mem_cmd <= next_mem_cmd;
            ext_rsp <= next_ext_rsp;
            cpu_rsp <= next_cpu_rsp;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_window_open;
        state == ST_RUN && cfg.wdt[cwdp_pkg::WIN_LSB +: 3] >= 3'h6
            |=> wdt.window_live == 3'h7 && wdt.window_sw && !wdt.window_key;
    endproperty
    a_window_open: assert property (p_window_open) else $error("open window code not decoded");

    property p_mode_always;
        state == ST_RUN && cfg.wdt[cwdp_pkg::MODE_LSB +: 2] == 2'h3 |=> wdt.run;
    endproperty
    a_mode_always: assert property (p_mode_always) else $error("watchdog not forced on");

    property p_mode_awake;
        state == ST_RUN && cfg.wdt[cwdp_pkg::MODE_LSB +: 2] == 2'h2 |=> wdt.run == !$past(sleep);
    endproperty
    a_mode_awake: assert property (p_mode_awake) else $error("awake mode wrong");

    property p_mode_soft;
        state == ST_RUN && cfg.wdt[cwdp_pkg::MODE_LSB +: 2] == 2'h1 |=> wdt.run == $past(watchdog_soft_on);
    endproperty
    a_mode_soft: assert property (p_mode_soft) else $error("soft mode ignores enable");

    property p_mode_off;
        state == ST_RUN && cfg.wdt[cwdp_pkg::MODE_LSB +: 2] == 2'h0 |=> !wdt.run;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("watchdog ran while off");

    property p_period;
        state == ST_RUN && cfg.wdt[4:0] <= 5'h12 |=> wdt.period_exp == $past(cfg.wdt[4:0]) + 5'h05;
    endproperty
    a_period: assert property (p_period) else $error("period divider wrong");

    property p_guard_all;
        sw_req && state == ST_RUN && cfg.mem[1:0] == 2'h0 |=> sw_ack && sw_blocked;
    endproperty
    a_guard_all: assert property (p_guard_all) else $error("self-write not blocked");

    property p_prog_zero;
        ext_take && !ext_req.write && ext_req.space == cwdp_pkg::SP_PROG && !cfg.prot[0]
            |=> !mem_cmd.valid ##1 ext_rsp.valid && ext_rsp.rdata == 14'h0000;
    endproperty
    a_prog_zero: assert property (p_prog_zero) else $error("protected read leaked");

    property p_ee_block;
        ext_take && ext_req.write && ext_req.space == cwdp_pkg::SP_EE && !cfg.prot[1]
            |=> !mem_cmd.valid ##1 ext_rsp.denied;
    endproperty
    a_ee_block: assert property (p_ee_block) else $error("protected eeprom write passed");

    property p_lvp_keep;
        ext_take && ext_req.write && ext_req.space == cwdp_pkg::SP_CFG && ext_req.addr == 16'h800A
            && lv_prog_active && cfg.mem[13] && !ext_req.wdata[13] |=> !mem_cmd.valid ##1 ext_rsp.denied;
    endproperty
    a_lvp_keep: assert property (p_lvp_keep) else $error("low-voltage enable cleared");

    property p_device_id_word;
        ext_take && !ext_req.write && ext_req.space == cwdp_pkg::SP_CFG && ext_req.addr == 16'h8006
            |-> ##2 ext_rsp.rdata == DEVICE_ID && !ext_rsp.denied;
    endproperty
    a_device_id_word: assert property (p_device_id_word) else $error("device id read wrong");
endmodule

//--- rtl/cwdp_wdt_decode.sv
// Purpose: combinational decode of the watchdog configuration word.
// Assumes: word already latched; sleep and soft enable are synchronous levels.
// Notes: outputs are registered by the caller.
module cwdp_wdt_decode (
    input wire logic [13:0] cfg_word,
    input wire logic sleep,
    input wire logic soft_on,
    output cwdp_pkg::cwdp_wdt_s dec
);
    // window, mode, period and clock source from one word
    always_comb begin
        logic [2:0] win;
        logic [1:0] mode;
        logic [4:0] per;
        logic [2:0] csel;
        win = cfg_word[cwdp_pkg::WIN_LSB +: 3];
        mode = cfg_word[cwdp_pkg::MODE_LSB +: 2];
        per = cfg_word[cwdp_pkg::PER_LSB +: 5];
        csel = cfg_word[cwdp_pkg::CLK_LSB +: 3];
        dec = '0;
        if (win >= cwdp_pkg::WIN_OPEN_MIN) begin
            dec.window_live = cwdp_pkg::WIN_FULL;
            dec.window_closed = cwdp_pkg::WIN_NONE;
            dec.window_sw = 1'b1;
            dec.window_key = 1'b0;
        end else begin
            dec.window_live = win;
            dec.window_closed = cwdp_pkg::WIN_FULL - win; // closed eighths of the period
            dec.window_sw = 1'b0;
            dec.window_key = 1'b1;
        end
        unique case (mode)
            cwdp_pkg::MODE_ALWAYS: dec.run = 1'b1; // runs in sleep too
            cwdp_pkg::MODE_AWAKE: dec.run = !sleep;
            cwdp_pkg::MODE_SOFT: dec.run = soft_on;
            cwdp_pkg::MODE_OFF: dec.run = 1'b0;
        endcase
        dec.period_live = per;
        if (per <= cwdp_pkg::PER_MAX) begin
            dec.period_exp = per + cwdp_pkg::PER_EXP_MIN;
        end else begin
            dec.period_exp = cwdp_pkg::PER_EXP_MIN; // out-of-table codes act as 1:32
        end
        // only the erased code leaves the period to software
        dec.period_sw = (per == cwdp_pkg::PER_ERASED);
        dec.clk_sw = 1'b0;
        if (csel == cwdp_pkg::CSEL_LF) begin
            dec.clk_sel = cwdp_pkg::WCLK_LF;
        end else if (csel == cwdp_pkg::CSEL_MF) begin
            dec.clk_sel = cwdp_pkg::WCLK_MF;
        end else if (csel == cwdp_pkg::CSEL_SW) begin
            dec.clk_sel = cwdp_pkg::WCLK_SW;
            dec.clk_sw = 1'b1;
        end else begin
            dec.clk_sel = cwdp_pkg::WCLK_RSVD;
        end
    end
endmodule

//--- verif/cwdp_prog_model.sv
// Purpose: programmer-side model that issues requests and serves memory reads.
// Assumes: xfer is entered in the time step of a rising edge.
// Notes: memory data is junk whenever no command is forwarded.
module cwdp_prog_model (
    input wire logic clk,
    input cwdp_pkg::cwdp_req_s mem_cmd,
    input cwdp_pkg::cwdp_rsp_s ext_rsp,
    output cwdp_pkg::cwdp_req_s ext_req,
    output logic [13:0] mem_rdata,
    output logic fwd
);
    timeunit 1ns;
    timeprecision 1ps;
    // inverse pattern off-command so a stale read cannot pass for real data
    assign mem_rdata = mem_cmd.valid ? 14'h2A5C : 14'h15A3;
    initial ext_req = '0;
    // remembers whether the last request reached memory; cleared as each request is sampled
    always @(posedge clk) begin
        if (ext_req.valid) begin
            fwd <= 1'b0;
        end else if (mem_cmd.valid) begin
            fwd <= 1'b1;
        end
    end
    // one-cycle request pulse; the answer stands for one cycle after the edge that follows the sampling edge
    task automatic xfer(input logic w, input logic [1:0] sp, input logic [15:0] a, output cwdp_pkg::cwdp_rsp_s r);
        ext_req <= {1'b1, w, sp, a, 14'h1111};
        @(posedge clk);
        ext_req <= '0;
        @(posedge clk);
        #1 r = ext_rsp;
        @(posedge clk);
    endtask
endmodule

//--- verif/cwdp_top_test.sv
// Purpose: self-checking bench for the configuration word decoder.
// Assumes: 8 ns clock, reset reloads the words from nvm_cfg.
// Notes: each boot changes the stored words, so scenarios reboot.
module cwdp_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, sleep, watchdog_soft_on, ext_reset_pin_enable, hv_detect, lv_prog_active;
    logic scanner_module_off, sw_req, cfg_loaded, reset_pin_is_reset, ext_reset_hold, prog_entry;
    logic scanner_avail, scanner_on, sw_ack, sw_blocked, fwd, ext_reset_pin_n, lv_key_ok;
    logic [13:0] sw_addr, mem_rdata;
    cwdp_pkg::cwdp_cfg_s nvm_cfg;
    cwdp_pkg::cwdp_req_s ext_req, cpu_req, mem_cmd;
    cwdp_pkg::cwdp_rsp_s ext_rsp, cpu_rsp, r;
    cwdp_pkg::cwdp_wdt_s wdt;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    cwdp_top dut (.*);
    cwdp_prog_model prog (.*);
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_of_test;
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // words are only captured at reset, so every new setting needs a boot
    task automatic boot(input logic [41:0] c);
        rst <= 1'b1;
        nvm_cfg <= c;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(cfg_loaded, 1'b1);
        @(posedge clk);
    endtask
    task automatic selfw(input logic [13:0] a, input logic e);
        sw_req <= 1'b1;
        sw_addr <= a;
        @(posedge clk);
        sw_req <= 1'b0;
        #1 chk({sw_ack, sw_blocked}, {1'b1, e});
        @(posedge clk);
    endtask
    task automatic cpu(input logic w, input logic [15:0] a, input logic [13:0] d);
        cpu_req <= {1'b1, w, 2'h2, a, d};
        @(posedge clk);
        cpu_req <= '0;
        #1 r = cpu_rsp;
        @(posedge clk);
    endtask
    // every watchdog mode against all sleep and soft-enable levels
    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            // self-write guard code follows the mode index
            boot({3'h1, 3'h5, 1'b0, i[1:0], 5'h13, 12'h7FF, i[1:0], 14'h3FFF});
            for (int k = 0; k < 4; k++) begin
                sleep <= k[0];
                watchdog_soft_on <= k[1];
                repeat (2) @(posedge clk);
                #1 chk(wdt.run, i == 3 || (i == 2 && !k[0]) || (i == 1 && k[1]));
                @(posedge clk);
            end
            // 00 guards everything, 01 up to 1FFF, 10 only the boot range, 11 nothing
            selfw(14'h1FFF, i < 2);
            selfw(14'h2000, i == 0);
        end
        #1 chk({wdt.window_live, wdt.window_closed, wdt.window_sw, wdt.window_key}, 8'hA9);
        chk({wdt.period_exp, wdt.period_sw, wdt.clk_sel}, 8'h29);
        @(posedge clk);
        prog.xfer(1'b0, 2'h2, 16'h8009, r);
        chk(r.rdata, 14'h0DF3);
    endtask
    // locked part: guarded memories, low-voltage port, identity words
    task automatic t_locked;
        boot({3'h7, 3'h6, 1'b1, 2'h3, 5'h12, 14'h3FFE, 14'h3FFC});
        lv_prog_active <= 1'b1;
        lv_key_ok <= 1'b1;
        ext_reset_pin_n <= 1'b0;
        scanner_module_off <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({wdt.window_live, wdt.window_sw, wdt.window_key, wdt.clk_sel}, 7'h7A);
        chk(wdt.period_exp, 5'h17);
        // low-voltage enable set: key enters, pin resets although its enable bit is clear
        chk({prog_entry, reset_pin_is_reset, ext_reset_hold}, 3'h7);
        chk({scanner_avail, scanner_on}, 2'h2);
        @(posedge clk);
        for (int s = 0; s < 2; s++) begin
            prog.xfer(1'b0, s[1:0], 16'h0010, r);
            chk({fwd, r.rdata}, 15'h0000);
            prog.xfer(1'b1, s[1:0], 16'h0010, r);
            chk({fwd, r.denied}, 2'h1);
        end
        prog.xfer(1'b1, 2'h2, 16'h800A, r);
        chk(r.denied, 1'b1);
        prog.xfer(1'b1, 2'h2, 16'h8006, r);
        chk(r.denied, 1'b1);
        prog.xfer(1'b0, 2'h2, 16'h8006, r);
        chk(r.rdata, 14'h1234);
        prog.xfer(1'b0, 2'h2, 16'h8005, r);
        chk(r.rdata, 14'h2042);
        selfw(14'h01FF, 1'b1);
        selfw(14'h0200, 1'b0);
        lv_prog_active <= 1'b0;
        lv_key_ok <= 1'b0;
        ext_reset_pin_n <= 1'b1;
        scanner_module_off <= 1'b0;
    endtask
    // open part: forwarded reads, user-id words, high-voltage entry
    task automatic t_open;
        boot({14'h3FFF, 14'h1FFF, 14'h3FFF});
        hv_detect <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({prog_entry, reset_pin_is_reset, scanner_avail, scanner_on}, 4'hB);
        @(posedge clk);
        prog.xfer(1'b0, 2'h0, 16'h0123, r);
        chk({r.valid, fwd, r.rdata}, 16'hEA5C);
        cpu(1'b1, 16'h8002, 14'h0ABC);
        chk({r.valid, r.denied}, 2'h2);
        cpu(1'b0, 16'h8002, 14'h0000);
        chk(r.rdata, 14'h0ABC);
        // low-voltage enable clear: the key alone does not enter, the enable bit rules the pin
        hv_detect <= 1'b0;
        lv_key_ok <= 1'b1;
        ext_reset_pin_enable <= 1'b1;
        ext_reset_pin_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({prog_entry, reset_pin_is_reset, ext_reset_hold}, 3'h3);
    endtask
    initial begin
        rst = 1'b1;
        nvm_cfg = '1;
        {sleep, watchdog_soft_on, ext_reset_pin_enable, hv_detect, lv_prog_active} = 5'h00;
        {scanner_module_off, sw_req, sw_addr} = 16'h0000;
        {ext_reset_pin_n, lv_key_ok} = 2'h2;
        cpu_req = '0;
        t_modes;
        t_locked;
        t_open;
        end_of_test;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test;
        end
    end
endmodule
